//--- rtl/dpbr_pkg.sv
package dpbr_pkg;

    typedef enum logic [1:0] {
        DPBR_ORG_256X16  = 2'h0,
        DPBR_ORG_512X8   = 2'h1,
        DPBR_ORG_1024X4  = 2'h2,
        DPBR_ORG_2048X2  = 2'h3
    } dpbr_org_t;

    // bit 1 picks the write edge, bit 0 the read edge
    typedef enum logic [1:0] {
        DPBR_POS_BOTH_EDGE_VARIANT = 2'h0,
        NEG_RD_EDGE_VARIANT        = 2'h1,
        NEG_WR_EDGE_VARIANT        = 2'h2,
        NEG_BOTH_EDGE_VARIANT      = 2'h3
    } dpbr_variant_t;

    localparam int unsigned DPBR_CAPACITY_BITS = 4096;
    localparam int unsigned DPBR_LOC_MAX_W     = 11;
    localparam int unsigned DPBR_WORD_MAX_W    = 16;
    localparam int unsigned DPBR_INHIBIT_W     = 16;

    localparam int unsigned DPBR_PCLK_NS       = 4;
    localparam int unsigned DPBR_HALF_NS       = 20;
    localparam int unsigned DPBR_HALF_CYC      =
        (DPBR_HALF_NS + DPBR_PCLK_NS - 1) / DPBR_PCLK_NS;
    localparam int unsigned DPBR_SETTLE_CYC    = 8;

    localparam logic [7:0] DPBR_OFS_CTRL     = 8'h00;
    localparam logic [7:0] DPBR_OFS_LOCATION = 8'h04;
    localparam logic [7:0] DPBR_OFS_WR_WORD  = 8'h08;
    localparam logic [7:0] DPBR_OFS_INHIBIT  = 8'h0C;
    localparam logic [7:0] DPBR_OFS_RD_WORD  = 8'h10;
    localparam logic [7:0] DPBR_OFS_STATUS   = 8'h14;

    localparam int unsigned DPBR_CTRL_GO_WR_BIT  = 0;
    localparam int unsigned DPBR_CTRL_GO_RD_BIT  = 1;
    localparam int unsigned DPBR_STAT_BUSY_BIT   = 0;
    localparam int unsigned DPBR_STAT_VALID_BIT  = 1;

    function automatic int unsigned dpbr_word_w(dpbr_org_t org);
        unique case (org)
            DPBR_ORG_256X16: return 16;
            DPBR_ORG_512X8:  return 8;
            DPBR_ORG_1024X4: return 4;
            DPBR_ORG_2048X2: return 2;
        endcase
    endfunction : dpbr_word_w

endpackage : dpbr_pkg

//--- rtl/dpbr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dpbr_if;
    import dpbr_pkg::*;

    logic                       wr_clock;
    logic                       wr_clock_gate;
    logic                       wr_port_enable;
    logic [DPBR_LOC_MAX_W-1:0]  wr_location;
    logic [DPBR_WORD_MAX_W-1:0] wr_word_in;
    logic [DPBR_INHIBIT_W-1:0]  bit_write_inhibit;
    logic                       rd_clock;
    logic                       rd_clock_gate;
    logic                       rd_port_enable;
    logic [DPBR_LOC_MAX_W-1:0]  rd_location;
    logic [DPBR_WORD_MAX_W-1:0] rd_word_out;

    modport mem (
        input  wr_clock, wr_clock_gate, wr_port_enable, wr_location,
        input  wr_word_in, bit_write_inhibit,
        input  rd_clock, rd_clock_gate, rd_port_enable, rd_location,
        output rd_word_out
    );

    modport user (
        output wr_clock, wr_clock_gate, wr_port_enable, wr_location,
        output wr_word_in, bit_write_inhibit,
        output rd_clock, rd_clock_gate, rd_port_enable, rd_location,
        input  rd_word_out
    );
endinterface : dpbr_if
`default_nettype wire

//--- rtl/dpbr_mem.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage pin sampler shared by every input bundle
module dpbr_sync3 #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q2,
    output logic      [W-1:0] q3
);
    logic [W-1:0] s1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            q2 <= '0;
            q3 <= '0;
        end else begin
            s1 <= d;
            q2 <= s1;
            q3 <= q2;
        end
    end
endmodule : dpbr_sync3

// turns a sampled pin clock into one pulse per active edge
module dpbr_edge_det #(
    parameter bit ACTIVE_LEVEL = 1'b1
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      edge_pulse
);
    logic s2;
    logic s3;
    logic level;
    logic agree;

    dpbr_sync3 #(.W(1)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pin),
        .q2      (s2),
        .q3      (s3)
    );

    // a glitch seen by only one stage never counts as an edge
    assign agree      = (s2 == s3);
    assign edge_pulse = agree && (s3 != level) && (s3 == ACTIVE_LEVEL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (agree) begin
            level <= s3;
        end
    end
endmodule : dpbr_edge_det

module dpbr_mem
    import dpbr_pkg::*;
#(
    parameter dpbr_pkg::dpbr_org_t     ORG        = dpbr_pkg::DPBR_ORG_256X16,
    parameter dpbr_pkg::dpbr_variant_t VARIANT    =
        dpbr_pkg::DPBR_POS_BOTH_EDGE_VARIANT,
    parameter bit                      PRELOAD_EN = 1'b1
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    dpbr_if.mem                                       port,
    input  wire logic                                 cfg_active,
    input  wire logic                                 preload_valid,
    input  wire logic [dpbr_pkg::DPBR_LOC_MAX_W-1:0]  preload_location,
    input  wire logic [dpbr_pkg::DPBR_WORD_MAX_W-1:0] preload_word
);
    import dpbr_pkg::*;

    localparam int unsigned DW    = dpbr_word_w(ORG);
    localparam int unsigned DEPTH = DPBR_CAPACITY_BITS / DW;
    localparam int unsigned AW    = $clog2(DEPTH);
    localparam bit          WR_ACTIVE = ~VARIANT[1];
    localparam bit          RD_ACTIVE = ~VARIANT[0];
    localparam int unsigned WB_W  =
        2 + DPBR_LOC_MAX_W + DPBR_WORD_MAX_W + DPBR_INHIBIT_W;
    localparam int unsigned RB_W  = 2 + DPBR_LOC_MAX_W;

    logic [DW-1:0]              mem [DEPTH];
    logic [DW-1:0]              rd_q;

    logic [WB_W-1:0]            wr_bundle;
    logic [WB_W-1:0]            wr_s;
    logic [RB_W-1:0]            rd_bundle;
    logic [RB_W-1:0]            rd_s;

    logic                       wr_edge;
    logic                       rd_edge;
    logic                       w_gate;
    logic                       w_en;
    logic [DPBR_LOC_MAX_W-1:0]  w_loc_full;
    logic [DPBR_WORD_MAX_W-1:0] w_word_full;
    logic [DPBR_INHIBIT_W-1:0]  w_inh_full;
    logic                       r_gate;
    logic                       r_en;
    logic [DPBR_LOC_MAX_W-1:0]  r_loc_full;

    logic [AW-1:0]              w_loc;
    logic [AW-1:0]              r_loc;
    logic [AW-1:0]              p_loc;
    logic [DW-1:0]              w_word;
    logic [DW-1:0]              w_inh;
    logic [DW-1:0]              old_word;
    logic [DW-1:0]              merged;
    logic                       wr_hit;
    logic                       rd_hit;
    logic                       preload_hit;

    assign wr_bundle = {port.wr_clock_gate, port.wr_port_enable,
                        port.wr_location, port.wr_word_in,
                        port.bit_write_inhibit};
    assign rd_bundle = {port.rd_clock_gate, port.rd_port_enable,
                        port.rd_location};

    // data rides the same three stages as its clock, so the
    // values seen at the edge pulse are the ones set up before it
    dpbr_sync3 #(.W(WB_W)) u_wr_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (wr_bundle),
        .q2      (),
        .q3      (wr_s)
    );

    dpbr_sync3 #(.W(RB_W)) u_rd_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (rd_bundle),
        .q2      (),
        .q3      (rd_s)
    );

    dpbr_edge_det #(.ACTIVE_LEVEL(WR_ACTIVE)) u_wr_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (port.wr_clock),
        .edge_pulse (wr_edge)
    );

    dpbr_edge_det #(.ACTIVE_LEVEL(RD_ACTIVE)) u_rd_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (port.rd_clock),
        .edge_pulse (rd_edge)
    );

    assign {w_gate, w_en, w_loc_full, w_word_full, w_inh_full} = wr_s;
    assign {r_gate, r_en, r_loc_full} = rd_s;

    // narrower organisations use the low bits of each bus
    assign w_loc  = w_loc_full[AW-1:0];
    assign r_loc  = r_loc_full[AW-1:0];
    assign p_loc  = preload_location[AW-1:0];
    assign w_word = w_word_full[DW-1:0];

    // only the widest organisation has an inhibit input
    assign w_inh  = (DW == DPBR_INHIBIT_W) ? w_inh_full[DW-1:0]
                                           : '0;

    assign old_word = mem[w_loc];

    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_bit
            assign merged[gi] = w_inh[gi] ? old_word[gi]
                                          : w_word[gi];
        end
    endgenerate

    // a stopped gate swallows either edge; a running configuration swallows only the write edge
    assign wr_hit = wr_edge && w_gate && w_en && !cfg_active;
    assign rd_hit = rd_edge && r_gate && r_en;
    assign preload_hit = PRELOAD_EN && cfg_active && preload_valid;

    // array has no reset: contents survive reset and reconfiguration
    always_ff @(posedge pclk) begin
        if (preload_hit) begin
            mem[p_loc] <= preload_word[DW-1:0];
        end else if (wr_hit) begin
            mem[w_loc] <= merged;
        end
    end

    // no reset here on purpose; undefined until the first read.
    // a read racing a write to its location returns the old word
    always_ff @(posedge pclk) begin
        if (rd_hit) begin
            rd_q <= mem[r_loc];
        end
    end

    assign port.rd_word_out = DPBR_WORD_MAX_W'(rd_q);

endmodule : dpbr_mem
`default_nettype wire

//--- rtl/dpbr_user.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module dpbr_user
    import dpbr_pkg::*;
#(
    parameter dpbr_pkg::dpbr_variant_t VARIANT    =
        dpbr_pkg::DPBR_POS_BOTH_EDGE_VARIANT,
    parameter int unsigned             HALF_CYC   = dpbr_pkg::DPBR_HALF_CYC,
    parameter int unsigned             SETTLE_CYC = dpbr_pkg::DPBR_SETTLE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    dpbr_if.user             port
);
    import dpbr_pkg::*;

    localparam bit WR_IDLE = VARIANT[1];
    localparam bit RD_IDLE = VARIANT[0];

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_ACTIVE = 5'h04,
        ST_RETURN = 5'h08,
        ST_SETTLE = 5'h10
    } dpbr_state_t;

    dpbr_state_t                state;
    logic [15:0]                div;
    logic [15:0]                settle;
    logic                       half_tick;
    logic                       op_read;
    logic                       go_wr;
    logic                       go_rd;
    logic                       go;
    logic                       setup_ph;
    logic                       wr_acc;
    logic [DPBR_LOC_MAX_W-1:0]  location;
    logic [DPBR_WORD_MAX_W-1:0] wr_word;
    logic [DPBR_INHIBIT_W-1:0]  inhibit;
    logic [DPBR_WORD_MAX_W-1:0] rd_word;
    logic                       rd_valid;
    logic [DPBR_WORD_MAX_W-1:0] rs1;
    logic [DPBR_WORD_MAX_W-1:0] rs2;
    logic [DPBR_WORD_MAX_W-1:0] rs3;
    logic                       known;

    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign pready   = penable;
    assign go_wr    = wr_acc && (paddr == DPBR_OFS_CTRL)
                      && pwdata[DPBR_CTRL_GO_WR_BIT];
    assign go_rd    = wr_acc && (paddr == DPBR_OFS_CTRL)
                      && pwdata[DPBR_CTRL_GO_RD_BIT];
    // one operation at a time, write wins and a read asked with it is dropped: never overlap ports
    assign go       = (go_wr || go_rd) && (state == ST_IDLE);
    assign half_tick = (div == 16'(HALF_CYC - 1));
    assign known    = (paddr == DPBR_OFS_CTRL) || (paddr == DPBR_OFS_LOCATION)
                      || (paddr == DPBR_OFS_WR_WORD)
                      || (paddr == DPBR_OFS_INHIBIT)
                      || (paddr == DPBR_OFS_RD_WORD)
                      || (paddr == DPBR_OFS_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 16'h0000;
        end else begin
            div <= half_tick ? 16'h0000 : div + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            location <= '0;
            wr_word  <= '0;
            inhibit  <= '0;
        end else if (wr_acc) begin
            if (paddr == DPBR_OFS_LOCATION) begin
                location <= pwdata[DPBR_LOC_MAX_W-1:0];
            end
            if (paddr == DPBR_OFS_WR_WORD) begin
                wr_word <= pwdata[DPBR_WORD_MAX_W-1:0];
            end
            if (paddr == DPBR_OFS_INHIBIT) begin
                inhibit <= pwdata[DPBR_INHIBIT_W-1:0];
            end
        end
    end

    // read data and error are both settled in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= !known;
            unique case (paddr)
                DPBR_OFS_LOCATION: prdata <= 32'(location);
                DPBR_OFS_WR_WORD:  prdata <= 32'(wr_word);
                DPBR_OFS_INHIBIT:  prdata <= 32'(inhibit);
                DPBR_OFS_RD_WORD:  prdata <= 32'(rd_word);
                DPBR_OFS_STATUS:   prdata <= 32'({rd_valid,
                                                 state != ST_IDLE});
                default:           prdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            op_read <= 1'b0;
            settle  <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: if (go) begin
                    state   <= ST_SETUP;
                    op_read <= !go_wr;
                end
                ST_SETUP:  if (half_tick) state <= ST_ACTIVE;
                ST_ACTIVE: if (half_tick) state <= ST_RETURN;
                ST_RETURN: if (half_tick) begin
                    state  <= op_read ? ST_SETTLE : ST_IDLE;
                    settle <= 16'h0000;
                end
                ST_SETTLE: begin
                    settle <= settle + 16'h0001;
                    if (settle == 16'(SETTLE_CYC - 1)) state <= ST_IDLE;
                end
            endcase
        end
    end

    // pins: gates stay low whenever no operation runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle level from reset on, so no pin edge at release
            port.wr_clock          <= WR_IDLE;
            port.rd_clock          <= RD_IDLE;
            port.wr_clock_gate     <= 1'b0;
            port.wr_port_enable    <= 1'b0;
            port.rd_clock_gate     <= 1'b0;
            port.rd_port_enable    <= 1'b0;
            port.wr_location       <= '0;
            port.wr_word_in        <= '0;
            port.bit_write_inhibit <= '0;
            port.rd_location       <= '0;
        end else begin
            if (state == ST_IDLE) begin
                port.wr_clock <= WR_IDLE;
                port.rd_clock <= RD_IDLE;
            end
            if (go && go_wr) begin
                port.wr_location       <= location;
                port.wr_word_in        <= wr_word;
                port.bit_write_inhibit <= inhibit;
                port.wr_port_enable    <= 1'b1;
                port.wr_clock_gate     <= 1'b1;
            end else if (go) begin
                port.rd_location    <= location;
                port.rd_port_enable <= 1'b1;
                port.rd_clock_gate  <= 1'b1;
            end
            if (state == ST_SETUP && half_tick) begin
                if (op_read) port.rd_clock <= !RD_IDLE;
                else         port.wr_clock <= !WR_IDLE;
            end
            if (state == ST_ACTIVE && half_tick) begin
                port.wr_clock <= WR_IDLE;
                port.rd_clock <= RD_IDLE;
            end
            if (state == ST_RETURN && half_tick) begin
                port.wr_clock_gate  <= 1'b0;
                port.wr_port_enable <= 1'b0;
                port.rd_clock_gate  <= 1'b0;
                port.rd_port_enable <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs1 <= '0;
            rs2 <= '0;
            rs3 <= '0;
        end else begin
            rs1 <= port.rd_word_out;
            rs2 <= rs1;
            rs3 <= rs2;
        end
    end

    // valid only after a completed read; unwritten words stay suspect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_word  <= '0;
            rd_valid <= 1'b0;
        end else if (state == ST_SETTLE
                     && settle == 16'(SETTLE_CYC - 1)) begin
            rd_word  <= rs3;
            rd_valid <= 1'b1;
        end else if (go && go_rd && !go_wr) begin
            rd_valid <= 1'b0;
        end
    end

endmodule : dpbr_user
`default_nettype wire

//--- testbench/dpbr_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dpbr_properties
    import dpbr_pkg::*;
#(
    parameter dpbr_pkg::dpbr_variant_t VARIANT =
        dpbr_pkg::DPBR_POS_BOTH_EDGE_VARIANT
) (
    input wire logic                                 pclk,
    input wire logic                                 presetn,
    input wire logic                                 wr_clock,
    input wire logic                                 wr_clock_gate,
    input wire logic                                 wr_port_enable,
    input wire logic [dpbr_pkg::DPBR_LOC_MAX_W-1:0]  wr_location,
    input wire logic [dpbr_pkg::DPBR_WORD_MAX_W-1:0] wr_word_in,
    input wire logic [dpbr_pkg::DPBR_INHIBIT_W-1:0]  bit_write_inhibit,
    input wire logic                                 rd_clock,
    input wire logic                                 rd_clock_gate,
    input wire logic                                 rd_port_enable,
    input wire logic [dpbr_pkg::DPBR_LOC_MAX_W-1:0]  rd_location,
    input wire logic [dpbr_pkg::DPBR_WORD_MAX_W-1:0] rd_word_out
);
    logic       rd_clock_q;
    logic [3:0] since_rd;
    logic       rd_fire;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign rd_fire = (rd_clock != rd_clock_q) && (rd_clock != VARIANT[0])
                     && rd_clock_gate && rd_port_enable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_clock_q <= VARIANT[0];
        end else begin
            rd_clock_q <= rd_clock;
        end
    end

    // saturating, so a stale read edge can never excuse a late change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rd <= 4'hF;
        end else if (rd_fire) begin
            since_rd <= 4'h0;
        end else if (since_rd != 4'hF) begin
            since_rd <= since_rd + 4'h1;
        end
    end

    // active edge follows the variant, so every polarity is covered
    sequence wr_edge;
        $changed(wr_clock) && (wr_clock != VARIANT[1]);
    endsequence
    sequence rd_edge;
        $changed(rd_clock) && (rd_clock != VARIANT[0]);
    endsequence

    wr_edge_gated_a: assert property (
        wr_edge |-> wr_clock_gate && wr_port_enable)
        else $error("write edge without gate and enable");
    rd_edge_gated_a: assert property (
        rd_edge |-> rd_clock_gate && rd_port_enable)
        else $error("read edge without gate and enable");
    wr_setup_hold_a: assert property (
        wr_edge |-> ($stable({wr_location, wr_word_in,
                              bit_write_inhibit}))[*4])
        else $error("write inputs moved around the edge");
    rd_loc_hold_a: assert property (
        rd_edge |-> ($stable(rd_location))[*4])
        else $error("read location moved around the edge");
    rd_word_hold_a: assert property (
        $changed(rd_word_out) |-> since_rd inside {[2:4]})
        else $error("read word changed without enabled read edge");
    wr_pulse_w_a: assert property (
        wr_edge |-> (wr_clock != VARIANT[1])[*5]
                    ##1 (wr_clock == VARIANT[1]))
        else $error("write clock active phase length wrong");
    idle_gates_a: assert property (
        (!wr_port_enable && !rd_port_enable)
        |-> !wr_clock_gate && !rd_clock_gate)
        else $error("gate left open while idle");
    wr_idle_lvl_a: assert property (
        !wr_clock_gate |-> wr_clock == VARIANT[1])
        else $error("write clock not at idle level");
    one_port_a: assert property (
        !(wr_clock_gate && rd_clock_gate))
        else $error("both ports busy at once");
    rd_seen_c: cover property (rd_fire ##[1:6] $changed(rd_word_out));
endmodule : dpbr_properties
`default_nettype wire

//--- testbench/dual_port_block_ram_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dual_port_block_ram_bench;
    import dpbr_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cfg_active;
    logic        preload_valid;
    logic [10:0] preload_location;
    logic [15:0] preload_word;
    logic [31:0] rd;
    logic        err;
    logic [15:0] held;
    logic [7:0]  locs [3];
    logic [15:0] words [3];
    int          n_mismatch;
    int          compares;

    dpbr_if u_dpbr_if ();
    dpbr_mem #(.ORG(DPBR_ORG_256X16), .PRELOAD_EN(1'b1)) u_dpbr_mem (
        .pclk(pclk), .presetn(presetn), .port(u_dpbr_if.mem),
        .cfg_active(cfg_active), .preload_valid(preload_valid),
        .preload_location(preload_location), .preload_word(preload_word));
    dpbr_user u_dpbr_user (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port(u_dpbr_if.user));
    dpbr_properties u_dpbr_properties (
        .pclk(pclk), .presetn(presetn),
        .wr_clock(u_dpbr_if.wr_clock), .wr_clock_gate(u_dpbr_if.wr_clock_gate),
        .wr_port_enable(u_dpbr_if.wr_port_enable),
        .wr_location(u_dpbr_if.wr_location), .wr_word_in(u_dpbr_if.wr_word_in),
        .bit_write_inhibit(u_dpbr_if.bit_write_inhibit),
        .rd_clock(u_dpbr_if.rd_clock), .rd_clock_gate(u_dpbr_if.rd_clock_gate),
        .rd_port_enable(u_dpbr_if.rd_port_enable),
        .rd_location(u_dpbr_if.rd_location), .rd_word_out(u_dpbr_if.rd_word_out));

    always #2 pclk = ~pclk;

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // request held from setup until the edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic mem_op(input logic [31:0] go);
        apb(1'b1, DPBR_OFS_CTRL, go);
        do begin
            apb(1'b0, DPBR_OFS_STATUS, 32'h0);
        end while (rd[DPBR_STAT_BUSY_BIT] !== 1'b0);
    endtask : mem_op

    task automatic mem_write(input logic [7:0] loc, input logic [15:0] w,
                             input logic [15:0] inh);
        apb(1'b1, DPBR_OFS_LOCATION, {24'h0, loc});
        apb(1'b1, DPBR_OFS_WR_WORD, {16'h0, w});
        apb(1'b1, DPBR_OFS_INHIBIT, {16'h0, inh});
        mem_op(32'h1);
    endtask : mem_write

    task automatic mem_read(input logic [7:0] loc);
        apb(1'b1, DPBR_OFS_LOCATION, {24'h0, loc});
        mem_op(32'h2);
        apb(1'b0, DPBR_OFS_RD_WORD, 32'h0);
    endtask : mem_read

    initial begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cfg_active = 1'b1;
        preload_valid = 1'b0;
        preload_location = 11'h000;
        preload_word = 16'h0000;
        locs = '{8'h00, 8'hFF, 8'h80};
        words = '{16'h1234, 16'hBEEF, 16'h5A0F};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check({16'h0, u_dpbr_if.rd_word_out}, {16'h0, 16'hXXXX});
        @(posedge pclk);
        preload_location <= 11'h005;
        preload_word <= 16'hA5A5;
        preload_valid <= 1'b1;
        @(posedge pclk);
        preload_valid <= 1'b0;
        mem_write(8'h05, 16'h1111, 16'h0000);
        @(posedge pclk);
        cfg_active <= 1'b0;
        preload_word <= 16'h0000;
        preload_valid <= 1'b1;
        @(posedge pclk);
        preload_valid <= 1'b0;
        mem_read(8'h05);
        check(rd, 32'h0000A5A5);
        apb(1'b0, DPBR_OFS_STATUS, 32'h0);
        check(rd & 32'h3, 32'h2);
        // all writes first, so reads prove nothing was overwritten
        for (int i = 0; i < 3; i++) mem_write(locs[i], words[i], 16'h0000);
        for (int i = 0; i < 3; i++) begin
            mem_read(locs[i]);
            check(rd, {16'h0, words[i]});
            check({16'h0, u_dpbr_if.rd_word_out}, {16'h0, words[i]});
        end
        mem_write(8'h00, 16'hFFFF, 16'hFF00);
        mem_read(8'h00);
        check(rd, 32'h000012FF);
        mem_write(8'h00, 16'h0000, 16'hFFFF);
        mem_read(8'h00);
        check(rd, 32'h000012FF);
        held = u_dpbr_if.rd_word_out;
        mem_write(8'h80, 16'h7777, 16'h0000);
        apb(1'b1, DPBR_OFS_RD_WORD, 32'h0000DEAD);
        check({16'h0, u_dpbr_if.rd_word_out}, {16'h0, held});
        apb(1'b0, DPBR_OFS_RD_WORD, 32'h0);
        check(rd, {16'h0, held});
        mem_read(8'h80);
        check(rd, 32'h00007777);
        // mid-run reset: read register and array both keep their data
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check({16'h0, u_dpbr_if.rd_word_out}, 32'h00007777);
        mem_read(8'hFF);
        check(rd, 32'h0000BEEF);
        apb(1'b0, 8'h3C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        final_report();
    end
endmodule : dual_port_block_ram_bench
`default_nettype wire
